// *** rtl/wdog_pkg.sv ***
package wdog_pkg;
    localparam logic [3:0]  CMD_OFF       = 4'h0;
    localparam logic [3:0]  CFG_OFF       = 4'h4;
    localparam logic [3:0]  FLG_OFF       = 4'h8;
    localparam logic [31:0] CFG_RESET     = 32'h3fff2fff;
    localparam logic [7:0]  CMD_PASSWORD  = 8'ha5;
    localparam int          KEY_MSB       = 31;
    localparam int          KEY_LSB       = 24;
    localparam int          RESTART_BIT   = 0;
    localparam int          LOAD_LSB      = 0;
    localparam int          IRQEN_BIT     = 12;
    localparam int          RSTEN_BIT     = 13;
    localparam int          PROC_BIT      = 14;
    localparam int          DIS_BIT       = 15;
    localparam int          WIN_LSB       = 16;
    localparam int          DBG_BIT       = 28;
    localparam int          IDLE_BIT      = 29;
    localparam int          UNF_BIT       = 0;
    localparam int          ERR_BIT       = 1;
    localparam int          CNT_W         = 12;
    localparam int          PRESCALE      = 128;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// *** rtl/windowed_watchdog_timer.sv ***
`timescale 1ns/1ns
module windowed_watchdog_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        debug_state,
    input  wire logic        system_idle,
    output logic             fault_irq,
    output logic             fault_out,
    output logic             fault_proc_only
);
    localparam int CNT_W = wdog_pkg::CNT_W;
    // axi write side
    logic        aw_have_r, aw_have_nxt;
    logic        w_have_r, w_have_nxt;
    logic [3:0]  aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0]  w_strb_r, w_strb_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        wr_fire;
    // axi read side
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic        rd_fire;
    logic        flag_read;
    // watchdog core
    logic [31:0]       cfg_r, cfg_nxt;
    logic              cfg_locked_r, cfg_locked_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    logic [6:0]        pre_r, pre_nxt;
    logic              unf_r, unf_nxt;
    logic              err_r, err_nxt;
    logic              fault_r, fault_nxt;
    logic              proc_r, proc_nxt;
    logic              irq_r, irq_nxt;
    logic              dbg_s1_r, dbg_s2_r, idle_s1_r, idle_s2_r;
    logic              cmd_wr, cfg_wr, restart, halted, tick;

    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign flag_read = rd_fire && (s_axi_araddr[3:2] == wdog_pkg::FLG_OFF[3:2]);
    assign cmd_wr = wr_fire && (aw_addr_r[3:2] == wdog_pkg::CMD_OFF[3:2]) && (&w_strb_r);
    // password check aborts the whole command write
    assign restart = cmd_wr
        && (w_data_r[wdog_pkg::KEY_MSB:wdog_pkg::KEY_LSB] == wdog_pkg::CMD_PASSWORD)
        && w_data_r[wdog_pkg::RESTART_BIT];
    assign cfg_wr = wr_fire && (aw_addr_r[3:2] == wdog_pkg::CFG_OFF[3:2])
        && (&w_strb_r) && !cfg_locked_r;
    assign halted = (cfg_r[wdog_pkg::DBG_BIT] && dbg_s2_r)
        || (cfg_r[wdog_pkg::IDLE_BIT] && idle_s2_r);
    assign tick = !halted && !cfg_r[wdog_pkg::DIS_BIT]
        && (pre_r == 7'(wdog_pkg::PRESCALE - 1));

    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            // flag register is read-only, unmapped offsets refused
            bresp_nxt   = (aw_addr_r[3:2] == wdog_pkg::CMD_OFF[3:2]
                           || aw_addr_r[3:2] == wdog_pkg::CFG_OFF[3:2])
                          ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rd_fire) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = wdog_pkg::RESP_OKAY;
            case (s_axi_araddr[3:2])
                wdog_pkg::CMD_OFF[3:2]: rdata_nxt = 32'h0;
                wdog_pkg::CFG_OFF[3:2]: rdata_nxt = cfg_r;
                wdog_pkg::FLG_OFF[3:2]: rdata_nxt = {30'h0, err_r, unf_r};
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = wdog_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_comb begin
        cfg_nxt        = cfg_r;
        cfg_locked_nxt = cfg_locked_r;
        cnt_nxt        = cnt_r;
        pre_nxt        = pre_r;
        unf_nxt        = unf_r;
        err_nxt        = err_r;
        fault_nxt      = fault_r;
        proc_nxt       = proc_r;
        // status read clears first; events below win over it
        if (flag_read) begin
            unf_nxt   = 1'b0;
            err_nxt   = 1'b0;
            fault_nxt = 1'b0;
        end
        if (!halted) begin
            pre_nxt = 7'(pre_r + 7'h1);
        end
        if (tick) begin
            if (cnt_r == '0) begin
                unf_nxt = 1'b1;
                cnt_nxt = cfg_r[wdog_pkg::LOAD_LSB +: CNT_W];
                if (cfg_r[wdog_pkg::RSTEN_BIT]) begin
                    fault_nxt = 1'b1;
                    proc_nxt  = cfg_r[wdog_pkg::PROC_BIT];
                end
            end else begin
                cnt_nxt = cnt_r - 12'h1;
            end
        end
        if (cfg_wr) begin
            cfg_nxt        = w_data_r & 32'h3fffffff;
            cfg_locked_nxt = 1'b1;
            cnt_nxt        = w_data_r[wdog_pkg::LOAD_LSB +: CNT_W];
            pre_nxt        = 7'h0;
        end else if (restart) begin
            // window violation checked even while disabled
            if (cnt_r > cfg_r[wdog_pkg::WIN_LSB +: CNT_W]) begin
                err_nxt = 1'b1;
                if (cfg_r[wdog_pkg::RSTEN_BIT]) begin
                    fault_nxt = 1'b1;
                    proc_nxt  = cfg_r[wdog_pkg::PROC_BIT];
                end
            end else begin
                cnt_nxt = cfg_r[wdog_pkg::LOAD_LSB +: CNT_W];
                pre_nxt = 7'h0;
            end
        end
        irq_nxt = cfg_nxt[wdog_pkg::IRQEN_BIT] && (unf_nxt || err_nxt);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0;
            rresp_r   <= 2'h0;
            dbg_s1_r  <= 1'b0;
            dbg_s2_r  <= 1'b0;
            idle_s1_r <= 1'b0;
            idle_s2_r <= 1'b0;
            // processor reset, also driven by the watchdog reset itself
            cfg_r        <= wdog_pkg::CFG_RESET;
            cfg_locked_r <= 1'b0;
            cnt_r        <= wdog_pkg::CFG_RESET[CNT_W-1:0];
            pre_r        <= 7'h0;
            unf_r        <= 1'b0;
            err_r        <= 1'b0;
            fault_r      <= 1'b0;
            proc_r       <= 1'b0;
            irq_r        <= 1'b0;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            dbg_s1_r  <= debug_state;
            dbg_s2_r  <= dbg_s1_r;
            idle_s1_r <= system_idle;
            idle_s2_r <= idle_s1_r;
            cfg_r        <= cfg_nxt;
            cfg_locked_r <= cfg_locked_nxt;
            cnt_r        <= cnt_nxt;
            pre_r        <= pre_nxt;
            unf_r        <= unf_nxt;
            err_r        <= err_nxt;
            fault_r      <= fault_nxt;
            proc_r       <= proc_nxt;
            irq_r        <= irq_nxt;
        end
    end

    // ready only while the holding slot is empty
    assign s_axi_awready   = !aw_have_r && !bvalid_r;
    assign s_axi_wready    = !w_have_r && !bvalid_r;
    assign s_axi_bvalid    = bvalid_r;
    assign s_axi_bresp     = bresp_r;
    assign s_axi_arready   = !rvalid_r;
    assign s_axi_rvalid    = rvalid_r;
    assign s_axi_rdata     = rdata_r;
    assign s_axi_rresp     = rresp_r;
    assign fault_irq       = irq_r;
    assign fault_out       = fault_r;
    assign fault_proc_only = proc_r;

    cfg_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_locked_r |=> $stable(cfg_r))
        else $error("config changed after lock");
    bad_key_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmd_wr && w_data_r[31:24] != 8'ha5 && !flag_read && !tick)
        |=> $stable(cnt_r) && $stable(err_r))
        else $error("bad key had effect");
    restart_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (restart && !cfg_wr && cnt_r <= cfg_r[27:16])
        |=> cnt_r == $past(cfg_r[11:0]) && pre_r == 7'h0)
        else $error("restart did not reload");
    win_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (restart && !cfg_wr && cnt_r > cfg_r[27:16]) |=> err_r)
        else $error("window error missed");
    unf_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && cnt_r == 12'h0 && cfg_r[13]) |=> unf_r && fault_out)
        else $error("underflow not flagged");
    dis_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg_r[15] && !restart && !cfg_wr) |=> $stable(cnt_r))
        else $error("disabled counter moved");
    halt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (halted && !restart && !cfg_wr) |=> $stable(cnt_r) && $stable(pre_r))
        else $error("halted counter moved");
    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_irq |-> cfg_r[12] && (unf_r || err_r))
        else $error("interrupt without cause");
    read_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (flag_read && !tick && !restart) |=> !unf_r && !err_r && !fault_out)
        else $error("flag read did not clear");
endmodule

// *** verification/reset_ctl_model.sv ***
`timescale 1ns/1ns
// reset controller stand-in: a fault held for DELAY cycles becomes a reset pulse
module reset_ctl_model #(
    parameter int DELAY = 4
) (
    input  wire logic aclk,
    input  wire logic fault_out,
    input  wire logic fault_proc_only,
    output logic      rst_req_n,
    output int        resets,
    output logic      proc_seen
);
    int held;
    initial begin
        held = 0;
        rst_req_n = 1'b1;
        resets = 0;
        proc_seen = 1'b0;
    end
    // pulse is longer than one edge so the synchronous reset is seen
    always @(posedge aclk) begin
        held = fault_out ? held + 1 : 0;
        if (held == DELAY) begin
            proc_seen <= fault_proc_only;
            resets <= resets + 1;
            rst_req_n <= 1'b0;
            repeat (4) @(posedge aclk);
            rst_req_n <= 1'b1;
            held = 0;
        end
    end
endmodule

// *** verification/test_windowed_watchdog_timer.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_windowed_watchdog_timer;
    logic        aclk, bench_rstn, aresetn, rst_req_n, fault_irq, fault_out, fault_proc_only;
    logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, cfg_m;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        debug_state, system_idle, proc_seen, cfg_locked;
    int          mismatches = 0, total_checks = 0, seed = 99093, load, n, t0, resets, cyc = 0;
    assign aresetn = bench_rstn & rst_req_n;
    windowed_watchdog_timer dut_u (.*);
    reset_ctl_model #(.DELAY(4)) ctl_u (.aclk(aclk), .fault_out(fault_out),
        .fault_proc_only(fault_proc_only), .rst_req_n(rst_req_n), .resets(resets),
        .proc_seen(proc_seen));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w) && n < 200) begin
            @(negedge aclk);
            n++;
            if (s_axi_awready) aw = 1'b1;
            if (s_axi_wready) w = 1'b1;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        do begin @(negedge aclk); n++; end while (!s_axi_bvalid && n < 400);
        resp = s_axi_bresp;
        if (n >= 400) mismatches++;
        @(posedge aclk);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin @(negedge aclk); n++; end while (!s_axi_arready && n < 200);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge aclk); n++; end while (!s_axi_rvalid && n < 400);
        resp = s_axi_rresp;
        `CHK(s_axi_rdata, e)
        @(posedge aclk);
    endtask
    // model of the write-once config: bits 31:30 read back as zero
    task automatic cfgw(input logic [31:0] d);
        wr(wdog_pkg::CFG_OFF, d);
        if (!cfg_locked) cfg_m = d & 32'h3fffffff;
        cfg_locked = 1'b1;
    endtask
    task automatic do_reset;
        bench_rstn <= 1'b0;
        repeat (16) @(posedge aclk);
        bench_rstn <= 1'b1;
        @(posedge aclk);
    endtask
    task automatic sync_model;
        cfg_m = wdog_pkg::CFG_RESET;
        cfg_locked = 1'b0;
    endtask
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_arvalid, debug_state, system_idle, bench_rstn} = '0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        sync_model();
        do_reset();
        rchk(wdog_pkg::CFG_OFF, cfg_m);
        rchk(wdog_pkg::CMD_OFF, 32'h0);
        rchk(4'hc, 32'h0);
        `CHK(resp, wdog_pkg::RESP_SLVERR)
        wr(wdog_pkg::FLG_OFF, 32'h3);
        `CHK(resp, wdog_pkg::RESP_SLVERR)
        wr(wdog_pkg::CMD_OFF, {wdog_pkg::CMD_PASSWORD, 24'h1});
        `CHK(resp, wdog_pkg::RESP_OKAY)
        rchk(wdog_pkg::FLG_OFF, 32'h0);
        // underflow with interrupt only; debug held but halt is off
        load = 4 + ($random(seed) & 7);
        debug_state <= 1'b1;
        system_idle <= 1'($random(seed));
        t0 = cyc;
        cfgw({4'h0, 12'(load), 4'h1, 12'(load)});
        cfgw(32'h00001fff);
        rchk(wdog_pkg::CFG_OFF, cfg_m);
        while (!fault_irq && cyc - t0 < (load + 3) * 128) @(negedge aclk);
        `CHK((cyc - t0 >= load * 128) && (cyc - t0 <= (load + 2) * 128), 1'b1)
        `CHK(fault_irq, 1'b1)
        `CHK(fault_out, 1'b0)
        @(posedge aclk);
        rchk(wdog_pkg::FLG_OFF, 32'h1);
        `CHK(fault_irq, 1'b0)
        // window errors answered by the reset controller, both reset kinds
        do_reset();
        sync_model();
        for (int p = 1; p >= 0; p--) begin
            cfgw({4'h0, 12'h010, 1'b0, p[0], 2'b11, 12'h100});
            wr(wdog_pkg::CMD_OFF, {8'h5a, 24'h1});
            rchk(wdog_pkg::FLG_OFF, 32'h0);
            n = 0;
            wr(wdog_pkg::CMD_OFF, {wdog_pkg::CMD_PASSWORD, 24'h1});
            while (resets != 2 - p && n < 100) begin @(negedge aclk); n++; end
            `CHK(resets, 2 - p)
            `CHK(proc_seen, p[0])
            while (!aresetn) @(negedge aclk);
            @(posedge aclk);
            sync_model();
            rchk(wdog_pkg::FLG_OFF, 32'h0);
            rchk(wdog_pkg::CFG_OFF, cfg_m);
        end
        // disabled: no counting, window check still live
        cfgw({4'h0, 12'h001, 4'h8, 12'h020});
        wr(wdog_pkg::CMD_OFF, {wdog_pkg::CMD_PASSWORD, 24'h1});
        `CHK(fault_irq, 1'b0)
        `CHK(fault_out, 1'b0)
        rchk(wdog_pkg::FLG_OFF, 32'h2);
        repeat (34 * 128) @(posedge aclk);
        rchk(wdog_pkg::FLG_OFF, 32'h0);
        stop_test();
    end
    // whole run is under ten thousand cycles
    initial begin
        #(20 * 30000);
        mismatches++;
        stop_test();
    end
endmodule
